/* File: verilog/gha_pkg.sv */
package gha_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_MODE = 3'h4;
  localparam logic [2:0] OFF_STAT = 3'h4;
  localparam logic [2:0] OFF_AUX = 3'h5;
  localparam logic [2:0] OFF_ADDR = 3'h6;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int ADDR_SEL_BIT = 7;
  localparam logic [1:0] ADM_NONE = 2'h0;
  localparam logic [1:0] ADM_DUAL = 2'h1;
  localparam logic [1:0] ADM_EXT_SINGLE = 2'h2;
  localparam logic [1:0] ADM_EXT_DUAL = 2'h3;
  localparam logic [1:0] TRM_EOI_PULSE = 2'h0;
  localparam logic [1:0] TRM_CIC_PULSE = 2'h1;
  localparam logic [1:0] TRM_CIC_EOI = 2'h2;
  localparam logic [1:0] TRM_CIC_PULLUP = 2'h3;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Auxiliary port selectors
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_POLL = 3'h3;
  localparam logic [2:0] SEL_AUXA = 3'h4;
  localparam logic [2:0] SEL_AUXB = 3'h5;
  localparam logic [3:0] SEL_AUXE = 4'hC;
  localparam logic [3:0] SEL_AUXF = 4'hD;
  localparam logic [3:0] SEL_AUXG = 4'h4;
  localparam logic [3:0] SEL_AUXI = 4'hE;
  localparam logic [3:0] SEL_CLKDIV = 4'h2;

  // ----------------------------------------------------------------
  // Bus command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] CMD_UNT = 8'h5F;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SEC = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dt;
    logic dl;
    logic [4:0] ad;
  } gha_addr_t;

  typedef struct packed {
    logic ton;
    logic lon;
    logic [1:0] trm;
    logic [1:0] zero;
    logic [1:0] adm;
  } gha_mode_t;

  typedef struct packed {
    logic [4:0] pollResp;
    logic [4:0] auxA;
    logic [4:0] auxB;
    logic [3:0] auxE;
    logic [3:0] auxF;
    logic [3:0] auxG;
    logic [3:0] auxI;
    logic [3:0] clkDiv;
  } gha_hidden_t;

  typedef struct packed {
    logic tacs;
    logic spas;
    logic cids;
    logic cads;
    logic csbs;
    logic cshs;
    logic ppas;
    logic dtas;
  } gha_ifstate_t;

  typedef enum logic [1:0] {EX_IDLE, EX_WAIT, EX_HOST} gha_ext_t;

endpackage : gha_pkg

/* File: verilog/gha_hidden_regs.sv */
`timescale 1ns/1ps

module gha_hidden_regs
  import gha_pkg::*;
#(
  parameter int ADDR_W = 3
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire gha_ifstate_t ifState,
  input wire logic triggerCmd,
  input wire logic localUntalk,
  input wire logic localUnlisten,
  input wire logic busCmdValid,
  input wire logic [7:0] busCmdByte,
  input wire logic hostSecAccept,
  input wire logic hostSecReject,
  output gha_addr_t primaryAddr,
  output gha_addr_t secondaryAddr,
  output gha_hidden_t hiddenRegs,
  output gha_mode_t modeReg,
  output logic talkAddressed,
  output logic listenAddressed,
  output logic secWaiting,
  output logic transceiverCtrlPinA,
  output logic transceiverCtrlPinB
);

  if (ADDR_W < 3) $error("gha_hidden_regs: ADDR_W must be at least 3");

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire logic wrEn = regWr && clkEn;
  wire logic [2:0] offs = regAddr[2:0];
  wire logic hiZero = (ADDR_W == 3) ? 1'b1 : (regAddr >> 3) == '0;
  wire logic wrAddr = wrEn && hiZero && offs == OFF_ADDR;
  wire logic wrAux = wrEn && hiZero && offs == OFF_AUX;
  wire logic wrMode = wrEn && hiZero && offs == OFF_MODE;
  wire logic wrAddr0 = wrAddr && !regWrData[ADDR_SEL_BIT];
  wire logic wrAddr1 = wrAddr && regWrData[ADDR_SEL_BIT];
  wire logic [2:0] sel3 = regWrData[7:5];
  wire logic [3:0] sel4 = regWrData[7:4];
  // Any other pattern at the aux offset is a command, not a store
  wire logic wrPoll = wrAux && sel3 == SEL_POLL;
  wire logic wrAuxA = wrAux && sel3 == SEL_AUXA;
  wire logic wrAuxB = wrAux && sel3 == SEL_AUXB;
  wire logic wrAuxE = wrAux && sel4 == SEL_AUXE;
  wire logic wrAuxF = wrAux && sel4 == SEL_AUXF;
  wire logic wrAuxG = wrAux && sel4 == SEL_AUXG;
  wire logic wrAuxI = wrAux && sel4 == SEL_AUXI;
  wire logic wrClk = wrAux && sel4 == SEL_CLKDIV;

  // ----------------------------------------------------------------
  // Hidden storage
  // ----------------------------------------------------------------
  gha_addr_t addr0_r;
  gha_addr_t addr1_r;
  gha_hidden_t hid_r;
  gha_mode_t mode_r;

  // Write-only: nothing here feeds the read mux
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addr0_r <= ADDR_RST;
      addr1_r <= ADDR_RST;
    end
    else
    begin
      if (wrAddr0) addr0_r <= regWrData[6:0];
      if (wrAddr1) addr1_r <= regWrData[6:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hid_r <= '0;
    else
    begin
      if (wrPoll) hid_r.pollResp <= regWrData[4:0];
      if (wrAuxA) hid_r.auxA <= regWrData[4:0];
      if (wrAuxB) hid_r.auxB <= regWrData[4:0];
      if (wrAuxE) hid_r.auxE <= regWrData[3:0];
      if (wrAuxF) hid_r.auxF <= regWrData[3:0];
      if (wrAuxG) hid_r.auxG <= regWrData[3:0];
      if (wrAuxI) hid_r.auxI <= regWrData[3:0];
      if (wrClk) hid_r.clkDiv <= regWrData[3:0];
    end
  end

  // Whole byte is cleared for determinism, though only trm must be
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mode_r <= MODE_RST;
    else if (wrMode)
      mode_r <= regWrData;
  end

  // ----------------------------------------------------------------
  // Address recognition
  // ----------------------------------------------------------------
  wire logic [7:0] talk0 = TALK_BASE + {3'h0, addr0_r.ad};
  wire logic [7:0] talk1 = TALK_BASE + {3'h0, addr1_r.ad};
  wire logic [7:0] lstn0 = LISTEN_BASE + {3'h0, addr0_r.ad};
  wire logic [7:0] lstn1 = LISTEN_BASE + {3'h0, addr1_r.ad};
  wire logic [7:0] cmd = {1'b0, busCmdByte[6:0]};
  wire logic cmdOn = busCmdValid && clkEn;
  wire logic isSec = cmd[6:5] == GRP_SEC;
  wire logic isTalk = cmd[6:5] == GRP_TALK && cmd != CMD_UNT;
  wire logic hitT0 = !addr0_r.dt && cmd == talk0;
  wire logic hitT1 = !addr1_r.dt && cmd == talk1;
  wire logic hitL0 = !addr0_r.dl && cmd == lstn0;
  wire logic hitL1 = !addr1_r.dl && cmd == lstn1;
  // Dual and extended-dual compare both slots, extended-single only the first
  wire logic useBoth = mode_r.adm[0];
  wire logic hitT = hitT0 || (useBoth && hitT1);
  wire logic hitL = hitL0 || (useBoth && hitL1);
  wire logic secHit = isSec && cmd[4:0] == addr1_r.ad;

  gha_ext_t ext_r;
  gha_ext_t ext_nxt;
  logic pendT_r;
  logic pendT_nxt;
  logic pendL_r;
  logic pendL_nxt;
  logic talk_r;
  logic talk_nxt;
  logic listen_r;
  logic listen_nxt;
  logic setT;
  logic setL;

  always_comb
  begin
    ext_nxt = ext_r;
    pendT_nxt = pendT_r;
    pendL_nxt = pendL_r;
    setT = 1'b0;
    setL = 1'b0;
    if (cmdOn)
    begin
      unique case (mode_r.adm)
        ADM_NONE:
          ext_nxt = EX_IDLE;
        ADM_DUAL:
        begin
          setT = hitT;
          setL = hitL;
        end
        ADM_EXT_SINGLE, ADM_EXT_DUAL:
        begin
          if (ext_r == EX_WAIT && isSec)
          begin
            if (mode_r.adm == ADM_EXT_DUAL)
              ext_nxt = EX_HOST;
            else
            begin
              setT = pendT_r && secHit;
              setL = pendL_r && secHit;
              ext_nxt = EX_IDLE;
            end
          end
          else if (!isSec && (hitT || hitL))
          begin
            pendT_nxt = hitT;
            pendL_nxt = hitL;
            ext_nxt = EX_WAIT;
          end
          else if (!isSec && ext_r != EX_HOST)
            ext_nxt = EX_IDLE;
        end
      endcase
    end
    if (ext_r == EX_HOST && clkEn && mode_r.adm != ADM_NONE)
    begin
      if (hostSecAccept)
      begin
        setT = setT || pendT_r;
        setL = setL || pendL_r;
        ext_nxt = EX_IDLE;
      end
      else if (hostSecReject)
        ext_nxt = EX_IDLE;
    end
  end

  // Set wins over every clear so a same-cycle address is never lost
  wire logic tonWr = wrMode && regWrData[7];
  wire logic lonWr = wrMode && regWrData[6];
  wire logic untB = cmdOn && (cmd == CMD_UNT || (isTalk && !setT));
  wire logic unlB = cmdOn && cmd == CMD_UNL;

  always_comb
  begin
    talk_nxt = talk_r;
    listen_nxt = listen_r;
    if (untB || (localUntalk && clkEn))
      talk_nxt = 1'b0;
    if (unlB || (localUnlisten && clkEn))
      listen_nxt = 1'b0;
    if (setT || tonWr)
      talk_nxt = 1'b1;
    if (setL || lonWr)
      listen_nxt = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_r <= EX_IDLE;
      pendT_r <= 1'b0;
      pendL_r <= 1'b0;
      talk_r <= 1'b0;
      listen_r <= 1'b0;
    end
    else if (clkEn)
    begin
      ext_r <= ext_nxt;
      pendT_r <= pendT_nxt;
      pendL_r <= pendL_nxt;
      talk_r <= talk_nxt;
      listen_r <= listen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transceiver control
  // ----------------------------------------------------------------
  logic dtasPrev_r;
  logic trigger_r;
  wire logic cic = ifState.cids || ifState.cads;
  wire logic end_line_output_enable = ifState.tacs || ifState.spas
                     || (cic && !(ifState.csbs || ifState.cshs));
  wire logic pullEn = cic || !ifState.ppas;
  wire logic dtasRise = ifState.dtas && !dtasPrev_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dtasPrev_r <= 1'b0;
      trigger_r <= 1'b0;
    end
    else if (clkEn)
    begin
      dtasPrev_r <= ifState.dtas;
      trigger_r <= dtasRise || triggerCmd;
    end
  end

  // Pin A follows the interface state directly, and so does pin B in modes 2 and 3; in the pulse modes pin B is the registered trigger_r
  assign transceiverCtrlPinA = (mode_r.trm == TRM_EOI_PULSE) ? end_line_output_enable : cic;
  assign transceiverCtrlPinB = (mode_r.trm == TRM_CIC_PULLUP) ? pullEn
                             : (mode_r.trm == TRM_CIC_EOI) ? end_line_output_enable : trigger_r;

  // ----------------------------------------------------------------
  // Status readback
  // ----------------------------------------------------------------
  logic [7:0] rd_r;
  wire logic rdStat = regRd && hiZero && offs == OFF_STAT;
  wire logic [7:0] statByte = {cic, 3'h0, ext_r == EX_HOST,
                               ext_r == EX_WAIT, talk_r, listen_r};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rd_r <= RD_IDLE;
    else if (clkEn)
      rd_r <= rdStat ? statByte : RD_IDLE;
  end

  assign regRdData = rd_r;
  assign primaryAddr = addr0_r;
  assign secondaryAddr = addr1_r;
  assign hiddenRegs = hid_r;
  assign modeReg = mode_r;
  assign talkAddressed = talk_r;
  assign listenAddressed = listen_r;
  assign secWaiting = ext_r == EX_HOST;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_addr0Load;
    @(posedge sys_clk) disable iff (rst)
      wrAddr0 |=> addr0_r == $past(regWrData[6:0]) && $stable(addr1_r);
  endproperty
  a_addr0Load: assert property (p_addr0Load) else $error("first address not loaded");

  property p_addr1Load;
    @(posedge sys_clk) disable iff (rst)
      wrAddr && regWrData[7] |=> addr1_r.ad == $past(regWrData[4:0])
                                 && addr1_r.dt == $past(regWrData[6]);
  endproperty
  a_addr1Load: assert property (p_addr1Load) else $error("second address not loaded");

  property p_pollKeep;
    @(posedge sys_clk) disable iff (rst)
      wrAux && sel3 != SEL_POLL |=> $stable(hid_r.pollResp);
  endproperty
  a_pollKeep: assert property (p_pollKeep) else $error("parallel poll changed");

  property p_auxG;
    @(posedge sys_clk) disable iff (rst)
      wrAux && regWrData[7:4] == 4'h4 |=> hid_r.auxG == $past(regWrData[3:0]);
  endproperty
  a_auxG: assert property (p_auxG) else $error("aux G not stored");

  property p_noAddr;
    @(posedge sys_clk) disable iff (rst)
      clkEn && mode_r.adm == ADM_NONE && !talk_r && !listen_r && !wrMode
        |=> !talk_r && !listen_r;
  endproperty
  a_noAddr: assert property (p_noAddr) else $error("addressed in no-address mode");

  property p_dual;
    @(posedge sys_clk) disable iff (rst)
      cmdOn && mode_r.adm == ADM_DUAL && !addr1_r.dt
        && busCmdByte[6:0] == talk1[6:0] |=> talk_r;
  endproperty
  a_dual: assert property (p_dual) else $error("second address ignored");

  property p_lon;
    @(posedge sys_clk) disable iff (rst)
      wrMode && regWrData == 8'h70 |=> listen_r && mode_r.lon;
  endproperty
  a_lon: assert property (p_lon) else $error("listen only failed");

  property p_lut;
    @(posedge sys_clk) disable iff (rst)
      clkEn && localUntalk && !setT && !tonWr |=> !talk_r;
  endproperty
  a_lut: assert property (p_lut) else $error("local untalk ignored");

  property p_pinA;
    @(posedge sys_clk) disable iff (rst)
      mode_r.trm != TRM_EOI_PULSE |-> transceiverCtrlPinA == (ifState.cids || ifState.cads);
  endproperty
  a_pinA: assert property (p_pinA) else $error("pin A not controller flag");

  property p_pullUp;
    @(posedge sys_clk) disable iff (rst)
      mode_r.trm == TRM_CIC_PULLUP |-> transceiverCtrlPinB == (cic || !ifState.ppas);
  endproperty
  a_pullUp: assert property (p_pullUp) else $error("pull-up enable wrong");

  property p_trigger;
    @(posedge sys_clk) disable iff (rst)
      clkEn && ifState.dtas && !dtasPrev_r |=> trigger_r;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger pulse missing");

  c_dual: cover property (@(posedge sys_clk) disable iff (rst)
    mode_r.adm == ADM_DUAL && cmdOn ##1 talk_r);
  c_extSingle: cover property (@(posedge sys_clk) disable iff (rst)
    ext_r == EX_WAIT ##1 talk_r);
  c_extHost: cover property (@(posedge sys_clk) disable iff (rst)
    ext_r == EX_HOST ##[1:4] ext_r == EX_IDLE);
  c_ton: cover property (@(posedge sys_clk) disable iff (rst) tonWr ##1 talk_r);

endmodule : gha_hidden_regs

/* File: bench/gha_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host CPU side of the register port
// ----------------------------------------------------------------
module gha_host_model
  import gha_pkg::*;
(
  input wire logic sys_clk,
  output logic [2:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdData
);
  initial
  begin
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // Data is inverted after release so a stale byte never looks valid
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regWrData <= ~d;
    #1;
  endtask : wr

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
endmodule : gha_host_model

/* File: bench/gpib_hidden_reg_addr_mode_tb_top.sv */
`timescale 1ns/1ps

module gpib_hidden_reg_addr_mode_tb_top
  import gha_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  gha_ifstate_t ifState = '0;
  logic [4:0] ctl = 5'h00;
  logic busCmdValid = 1'b0;
  logic [7:0] busCmdByte = 8'h00;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  gha_addr_t primaryAddr;
  gha_addr_t secondaryAddr;
  gha_hidden_t hiddenRegs;
  gha_mode_t modeReg;
  logic talkAddressed;
  logic listenAddressed;
  logic secWaiting;
  logic pinA;
  logic pinB;
  logic [31:0] rngState = 32'h00001089;
  int err_count = 0;
  int comparisons = 0;
  int pri = 0;
  int sec = 0;
  int hid [8] = '{default: 0};

  always #10 sys_clk = ~sys_clk;

  gha_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  gha_hidden_regs #(.ADDR_W(3)) dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .ifState(ifState), .triggerCmd(ctl[4]), .localUntalk(ctl[3]),
    .localUnlisten(ctl[2]), .busCmdValid(busCmdValid), .busCmdByte(busCmdByte),
    .hostSecAccept(ctl[1]), .hostSecReject(ctl[0]), .primaryAddr(primaryAddr),
    .secondaryAddr(secondaryAddr), .hiddenRegs(hiddenRegs), .modeReg(modeReg),
    .talkAddressed(talkAddressed), .listenAddressed(listenAddressed),
    .secWaiting(secWaiting), .transceiverCtrlPinA(pinA), .transceiverCtrlPinB(pinB));

  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : rnd

  function automatic void model_wr(input logic [2:0] a, input logic [7:0] d);
    int s;
    s = -1;
    if (a == 3'h6 && d[7])
      sec = d[6:0];
    if (a == 3'h6 && !d[7])
      pri = d[6:0];
    if (a == 3'h5)
    begin
      case (d[7:4])
        4'h6, 4'h7: s = 0;
        4'h8, 4'h9: s = 1;
        4'hA, 4'hB: s = 2;
        4'hC: s = 3;
        4'hD: s = 4;
        4'h4: s = 5;
        4'hE: s = 6;
        4'h2: s = 7;
        default: s = -1;
      endcase
    end
    if (s >= 0 && s < 3)
      hid[s] = d[4:0];
    if (s >= 3)
      hid[s] = d[3:0];
  endfunction : model_wr

  function automatic logic [34:0] exp_hid();
    return {hid[0][4:0], hid[1][4:0], hid[2][4:0], hid[3][3:0], hid[4][3:0],
      hid[5][3:0], hid[6][3:0], hid[7][3:0]};
  endfunction : exp_hid

  function automatic logic [1:0] pins(input gha_ifstate_t s, input logic [1:0] trm);
    logic cic;
    logic eoi;
    logic pe;
    cic = s.cids | s.cads;
    eoi = s.tacs | s.spas | (cic & ~(s.csbs | s.cshs));
    pe = cic | ~s.ppas;
    case (trm)
      2'h0: return {eoi, 1'b0};
      2'h1: return {cic, 1'b0};
      2'h2: return {cic, eoi};
      default: return {cic, pe};
    endcase
  endfunction : pins

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wra(input logic [2:0] a, input logic [7:0] d);
    host.wr(a, d);
    model_wr(a, d);
  endtask : wra

  task automatic setm(input logic [7:0] m);
    host.wr(3'h4, m);
    chk(modeReg, m);
  endtask : setm

  task automatic cmd(input logic [7:0] b);
    @(posedge sys_clk);
    busCmdValid <= 1'b1;
    busCmdByte <= b;
    @(posedge sys_clk);
    busCmdValid <= 1'b0;
    busCmdByte <= ~b;
    #1;
  endtask : cmd

  task automatic pulse(input logic [4:0] m);
    @(posedge sys_clk);
    ctl <= m;
    @(posedge sys_clk);
    ctl <= 5'h00;
    #1;
  endtask : pulse

  task automatic conclude();
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude();
  end

  initial
  begin
    logic [7:0] v;
    logic [31:0] r;
    logic [2:0] a;
    logic [7:0] modes [6];
    modes = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h70, 8'hB0};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(modeReg.trm, 2'h0);
    // On average 11 in 16 writes hit the hidden offsets, the rest must be ignored
    repeat (100)
    begin
      r = rnd();
      a = r[3] ? (r[2] ? 3'h6 : 3'h5) : r[2:0];
      a = (a == 3'h4) ? 3'h5 : a;
      wra(a, r[15:8]);
      chk(primaryAddr, pri);
      chk(secondaryAddr, sec);
      chk(hiddenRegs, exp_hid());
    end
    wra(3'h5, 8'h4A);
    chk(hiddenRegs, exp_hid());
    // A frozen enable must swallow the strobe
    @(posedge sys_clk);
    clkEn <= 1'b0;
    host.wr(3'h6, 8'h1F);
    chk(primaryAddr, pri);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      host.rd(i[2:0], v);
      if (i != 4)
        chk(v, 8'h00);
    end
    foreach (modes[i])
      setm(modes[i]);
    // Listen-only and talk-only above leave both flags set
    pulse(5'h0C);
    chk({talkAddressed, listenAddressed}, 2'b00);
    wra(3'h6, 8'h05);
    wra(3'h6, 8'h8A);
    setm(8'h30);
    cmd(8'h45);
    chk(talkAddressed, 1'b0);
    cmd(8'h25);
    chk(listenAddressed, 1'b0);
    setm(8'h31);
    cmd(8'h45);
    chk(talkAddressed, 1'b1);
    host.rd(3'h4, v);
    chk(v[1:0], 2'b10);
    cmd(8'h5F);
    cmd(8'h2A);
    chk({talkAddressed, listenAddressed}, 2'b01);
    cmd(8'h4A);
    chk(talkAddressed, 1'b1);
    cmd(8'h3F);
    wra(3'h6, 8'h45);
    cmd(8'h45);
    chk({talkAddressed, listenAddressed}, 2'b00);
    wra(3'h6, 8'h05);
    setm(8'h32);
    cmd(8'h45);
    cmd(8'h6A);
    chk(talkAddressed, 1'b1);
    cmd(8'h5F);
    setm(8'h33);
    cmd(8'h45);
    cmd(8'h6A);
    chk(secWaiting, 1'b1);
    pulse(5'h02);
    chk(talkAddressed, 1'b1);
    cmd(8'h5F);
    cmd(8'h45);
    cmd(8'h6A);
    pulse(5'h01);
    chk({talkAddressed, secWaiting}, 2'b00);
    setm(8'h70);
    chk(listenAddressed, 1'b1);
    setm(8'h30);
    pulse(5'h04);
    chk(listenAddressed, 1'b0);
    setm(8'hB0);
    chk(talkAddressed, 1'b1);
    setm(8'h30);
    pulse(5'h08);
    chk(talkAddressed, 1'b0);
    for (int t = 0; t < 4; t++)
    begin
      setm({2'b00, t[1:0], 4'h0});
      repeat (8)
      begin
        r = rnd();
        @(posedge sys_clk);
        ifState <= gha_ifstate_t'(r[7:0] & 8'hFE);
        #1;
        chk({pinA, pinB}, pins(ifState, t[1:0]));
      end
    end
    setm(8'h00);
    ifState <= '0;
    pulse(5'h10);
    chk(pinB, 1'b1);
    @(posedge sys_clk);
    ifState <= gha_ifstate_t'(8'h01);
    #1;
    chk(pinB, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(pinB, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(pinB, 1'b0);
    setm(8'h30);
    @(posedge sys_clk);
    rst <= 1'b1;
    #1;
    chk(modeReg.trm, 2'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    conclude();
  end
endmodule : gpib_hidden_reg_addr_mode_tb_top
